// ### sba_pkg.sv
`default_nettype none

package sba_pkg;

   // Operation codes, one per arithmetic instruction
   typedef enum logic [3:0] {
      twos_complement_word = 4'h0,
      binary_add_word = 4'h1,
      binary_subtract_word = 4'h2,
      signed_multiply_word = 4'h3,
      signed_divide_word = 4'h4,
      twos_complement_long = 4'h5,
      binary_add_long = 4'h6,
      binary_subtract_long = 4'h7,
      signed_multiply_long = 4'h8,
      signed_divide_long = 4'h9
   } sba_op_t;

   // Control states of the top and of the divider
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DIV = 2'b10
   } sba_st_t;

   typedef enum logic [2:0] {
      DV_IDLE = 3'b001,
      DV_RUN = 3'b010,
      DV_DONE = 3'b100
   } sba_dv_st_t;

   // Signed ranges of one and two words
   localparam logic [15:0] WORD_MIN = 16'h8000;
   localparam logic [15:0] WORD_MAX = 16'h7fff;
   localparam logic [31:0] LONG_MIN = 32'h8000_0000;
   localparam logic [31:0] LONG_MAX = 32'h7fff_ffff;

   // Flag vector field positions and reset values
   localparam int FLG_CARRY = 0;
   localparam int FLG_EQUALS = 1;
   localparam int FLG_OVER = 2;
   localparam int FLG_UNDER = 3;
   localparam logic [3:0] RST_FLAGS = 4'h0;
   localparam logic [63:0] RST_RESULT = 64'h0;

   // Divider iterations, one quotient bit per cycle
   localparam logic [5:0] DIV_STEPS = 6'h20;

   // Exact 33-bit result above the signed maximum
   function automatic logic sba_over(input logic [32:0] e, input logic long_op);
      if (long_op) begin
         sba_over = $signed(e) > $signed({1'b0, LONG_MAX});
      end else begin
         sba_over = $signed(e) > $signed({17'h0, WORD_MAX});
      end
   endfunction

   // Exact 33-bit result below the signed minimum
   function automatic logic sba_under(input logic [32:0] e, input logic long_op);
      if (long_op) begin
         sba_under = $signed(e) < $signed({1'b1, LONG_MIN});
      end else begin
         sba_under = $signed(e) < $signed({17'h1ffff, WORD_MIN});
      end
   endfunction

   // Truncate an exact result to the stored words
   function automatic logic [63:0] sba_fit(input logic [32:0] e, input logic long_op);
      sba_fit = long_op ? {32'h0, e[31:0]} : {48'h0, e[15:0]};
   endfunction

   // Magnitude of a two's-complement word pair
   function automatic logic [31:0] sba_abs(input logic [31:0] v);
      sba_abs = v[31] ? (32'h0 - v) : v;
   endfunction

endpackage

`default_nettype wire

// ### sba_div_if.sv
`timescale 1ns/1ps
`default_nettype none

// Link between the controller and the division engine
interface sba_div_if;
   logic start;
   logic [31:0] dividend;
   logic [31:0] divisor;
   logic done;
   logic [32:0] quot;
   logic [31:0] rem;

   modport ctl (output start, output dividend, output divisor, input done, input quot, input rem);
   modport eng (input start, input dividend, input divisor, output done, output quot, output rem);
endinterface

`default_nettype wire

// ### sba_div.sv
`timescale 1ns/1ps
`default_nettype none

module sba_div
   import sba_pkg::*;
(
   input wire logic clock, // System clock
   input wire logic sys_rst, // Synchronous reset, high
   sba_div_if.eng dif // Operands in, quotient and remainder out
);

   sba_dv_st_t dst_ff, nxt_dst;
   logic [5:0] cnt_ff, nxt_cnt;
   logic [32:0] rem_ff, nxt_rem;
   logic [31:0] quo_ff, nxt_quo;
   logic [31:0] dvs_ff, nxt_dvs;
   logic neg_q_ff, nxt_neg_q;
   logic neg_r_ff, nxt_neg_r;
   logic [31:0] raw_dvd_ff, nxt_raw_dvd;
   logic [31:0] raw_dvs_ff, nxt_raw_dvs;
   logic [32:0] shifted;
   logic [32:0] trial;

   // One restoring step on the magnitudes
   assign shifted = {rem_ff[31:0], quo_ff[31]};
   assign trial = shifted - {1'b0, dvs_ff};

   // Next state of the engine
   always_comb begin
      nxt_dst = dst_ff;
      nxt_cnt = cnt_ff;
      nxt_rem = rem_ff;
      nxt_quo = quo_ff;
      nxt_dvs = dvs_ff;
      nxt_neg_q = neg_q_ff;
      nxt_neg_r = neg_r_ff;
      nxt_raw_dvd = raw_dvd_ff;
      nxt_raw_dvs = raw_dvs_ff;
      case (dst_ff)
         DV_IDLE: begin
            if (dif.start) begin
               nxt_dst = DV_RUN;
               nxt_cnt = 6'h0;
               nxt_rem = 33'h0;
               nxt_quo = sba_abs(dif.dividend);
               nxt_dvs = sba_abs(dif.divisor);
               nxt_neg_q = dif.dividend[31] ^ dif.divisor[31];
               nxt_neg_r = dif.dividend[31];
               nxt_raw_dvd = dif.dividend;
               nxt_raw_dvs = dif.divisor;
            end
         end
         DV_RUN: begin
            if (!trial[32]) begin
               nxt_rem = trial;
               nxt_quo = {quo_ff[30:0], 1'b1};
            end else begin
               nxt_rem = shifted;
               nxt_quo = {quo_ff[30:0], 1'b0};
            end
            nxt_cnt = cnt_ff + 6'h1;
            if (cnt_ff == DIV_STEPS - 6'h1) begin
               nxt_dst = DV_DONE;
            end
         end
         DV_DONE: begin
            nxt_dst = DV_IDLE;
         end
         default: begin
            nxt_dst = DV_IDLE;
         end
      endcase
   end

   // Engine registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         dst_ff <= DV_IDLE;
         cnt_ff <= 6'h0;
         rem_ff <= 33'h0;
         quo_ff <= 32'h0;
         dvs_ff <= 32'h0;
         neg_q_ff <= 1'b0;
         neg_r_ff <= 1'b0;
         raw_dvd_ff <= 32'h0;
         raw_dvs_ff <= 32'h0;
      end else begin
         dst_ff <= nxt_dst;
         cnt_ff <= nxt_cnt;
         rem_ff <= nxt_rem;
         quo_ff <= nxt_quo;
         dvs_ff <= nxt_dvs;
         neg_q_ff <= nxt_neg_q;
         neg_r_ff <= nxt_neg_r;
         raw_dvd_ff <= nxt_raw_dvd;
         raw_dvs_ff <= nxt_raw_dvs;
      end
   end

   // Signs restored: quotient by sign mix, remainder follows dividend
   assign dif.done = (dst_ff == DV_DONE);
   assign dif.quot = neg_q_ff ? (33'h0 - {1'b0, quo_ff}) : {1'b0, quo_ff};
   assign dif.rem = neg_r_ff ? (32'h0 - rem_ff[31:0]) : rem_ff[31:0];

   sequence s_dv_start;
      (dst_ff == DV_IDLE) && dif.start;
   endsequence

   AST_DIV_STEPS: assert property (@(posedge clock) disable iff (sys_rst)
      s_dv_start |-> !dif.done [*8] ##26 dif.done)
      else $error("divide did not finish after 33 cycles");

   AST_DIV_IDENTITY: assert property (@(posedge clock) disable iff (sys_rst)
      dif.done && (raw_dvs_ff != 32'h0) |->
      ($signed(dif.quot) * $signed({raw_dvs_ff[31], raw_dvs_ff}) + $signed({{34{dif.rem[31]}}, dif.rem}))
      == $signed({{34{raw_dvd_ff[31]}}, raw_dvd_ff}))
      else $error("quotient times divisor plus remainder differs from dividend");

   AST_DIV_REM_SIGN: assert property (@(posedge clock) disable iff (sys_rst)
      dif.done && (dif.rem != 32'h0) |-> dif.rem[31] == raw_dvd_ff[31])
      else $error("remainder sign differs from dividend sign");

endmodule // sba_div

`default_nettype wire

// ### sba_alu.sv
// Functional notes
// - Operands and results are two's complement, top bit of the quantity is sign.
// - One-word values span 8000 to 7fff hexadecimal.
// - Two-word values span 8000 0000 to 7fff ffff as one 32-bit quantity.
// - Word and long negate, add, subtract, multiply and divide on signed operands.
// - Carry set on addition carry out or negative subtraction result.
// - Equals set when the stored result of negate, add, subtract or multiply is zero, or when the divide quotient is zero.
// - Overflow set when a word add or subtract exceeds 7fff.
// - Overflow set when a long add or subtract exceeds 7fff ffff.
// - Underflow set when word add, subtract or negate falls below 8000.
// - Underflow set when long add, subtract or negate falls below 8000 0000.
// - Every operation clears each flag whose condition is not met; unknown codes keep all four flags.
`timescale 1ns/1ps
`default_nettype none

module sba_alu
   import sba_pkg::*;
(
   input wire logic clock, // System clock, 100 MHz
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic op_valid, // Operation request
   output logic op_ready, // Ready to take a request
   input wire logic [3:0] op_code, // Operation selector
   input wire logic [15:0] opnd_a_lo, // First operand, low word
   input wire logic [15:0] opnd_a_hi, // First operand, high word
   input wire logic [15:0] opnd_b_lo, // Second operand, low word
   input wire logic [15:0] opnd_b_hi, // Second operand, high word
   output logic res_valid, // Result pulse
   output logic [15:0] res_w0, // Result word 0
   output logic [15:0] res_w1, // Result word 1
   output logic [15:0] res_w2, // Result word 2
   output logic [15:0] res_w3, // Result word 3
   output logic flag_carry, // Carry flag
   output logic flag_equals, // Equals flag
   output logic flag_overflow, // Overflow flag
   output logic flag_underflow // Underflow flag
);

   sba_st_t st_ff, nxt_st;
   logic [63:0] res_ff, nxt_res;
   logic [3:0] flags_ff, nxt_flags;
   logic valid_ff, nxt_valid;
   logic long_ff, nxt_long;
   logic divz_ff, nxt_divz;
   logic [31:0] dvd_ff, nxt_dvd;

   logic accept;
   logic is_long;
   logic is_div;
   logic [31:0] a_w;
   logic [31:0] b_w;
   logic [32:0] a_x;
   logic [32:0] b_x;
   logic [32:0] sum_e;
   logic [32:0] dif_e;
   logic [32:0] neg_e;
   logic [32:0] usum;
   logic a_is_min;
   logic signed [63:0] prod;
   logic [32:0] dq;
   logic [31:0] dr;

   sba_div_if div_if();

   sba_div u_div (
      .clock(clock),
      .sys_rst(sys_rst),
      .dif(div_if.eng)
   );

   // Request handshake and decode
   assign op_ready = (st_ff == ST_IDLE);
   assign accept = op_valid && op_ready;
   assign is_long = (op_code == twos_complement_long) || (op_code == binary_add_long) ||
                    (op_code == binary_subtract_long) || (op_code == signed_multiply_long) ||
                    (op_code == signed_divide_long);
   assign is_div = (op_code == signed_divide_word) || (op_code == signed_divide_long);

   // Operand assembly, word operands sign-extended
   assign a_w = is_long ? {opnd_a_hi, opnd_a_lo} : {{16{opnd_a_lo[15]}}, opnd_a_lo};
   assign b_w = is_long ? {opnd_b_hi, opnd_b_lo} : {{16{opnd_b_lo[15]}}, opnd_b_lo};
   assign a_x = {a_w[31], a_w};
   assign b_x = {b_w[31], b_w};

   // Exact results, one bit wider than the widest operand, the product twice as wide
   assign sum_e = a_x + b_x;
   assign dif_e = a_x - b_x;
   assign neg_e = 33'h0 - a_x;
   assign usum = is_long ? ({1'b0, a_w} + {1'b0, b_w}) : ({17'h0, opnd_a_lo} + {17'h0, opnd_b_lo});
   assign a_is_min = is_long ? (a_w == LONG_MIN) : (opnd_a_lo == WORD_MIN);
   assign prod = $signed(a_w) * $signed(b_w);

   // Divider hookup, engine runs for a zero divisor too, its result replaced when done
   assign div_if.start = accept && is_div;
   assign div_if.dividend = a_w;
   assign div_if.divisor = b_w;
   assign dq = divz_ff ? 33'h0 : div_if.quot;
   assign dr = divz_ff ? dvd_ff : div_if.rem;

   // Next results and flags
   always_comb begin
      nxt_st = st_ff;
      nxt_res = res_ff;
      nxt_flags = flags_ff;
      nxt_valid = 1'b0;
      nxt_long = long_ff;
      nxt_divz = divz_ff;
      nxt_dvd = dvd_ff;
      case (st_ff)
         ST_IDLE: begin
            if (accept && is_div) begin
               nxt_st = ST_DIV;
               nxt_long = is_long;
               nxt_divz = (b_w == 32'h0);
               nxt_dvd = a_w;
            end else if (accept) begin
               nxt_valid = 1'b1;
               case (op_code)
                  twos_complement_word, twos_complement_long: begin
                     nxt_res = sba_fit(neg_e, is_long);
                     nxt_flags[FLG_CARRY] = 1'b0;
                     nxt_flags[FLG_EQUALS] = (nxt_res == 64'h0);
                     nxt_flags[FLG_OVER] = 1'b0;
                     nxt_flags[FLG_UNDER] = a_is_min;
                  end
                  binary_add_word, binary_add_long: begin
                     nxt_res = sba_fit(sum_e, is_long);
                     nxt_flags[FLG_CARRY] = is_long ? usum[32] : usum[16];
                     nxt_flags[FLG_EQUALS] = (nxt_res == 64'h0);
                     nxt_flags[FLG_OVER] = sba_over(sum_e, is_long);
                     nxt_flags[FLG_UNDER] = sba_under(sum_e, is_long);
                  end
                  binary_subtract_word, binary_subtract_long: begin
                     nxt_res = sba_fit(dif_e, is_long);
                     nxt_flags[FLG_CARRY] = dif_e[32];
                     nxt_flags[FLG_EQUALS] = (nxt_res == 64'h0);
                     nxt_flags[FLG_OVER] = sba_over(dif_e, is_long);
                     nxt_flags[FLG_UNDER] = sba_under(dif_e, is_long);
                  end
                  signed_multiply_word, signed_multiply_long: begin
                     nxt_res = is_long ? prod : {32'h0, prod[31:0]};
                     nxt_flags[FLG_CARRY] = 1'b0;
                     nxt_flags[FLG_EQUALS] = (prod == 64'h0);
                     nxt_flags[FLG_OVER] = 1'b0;
                     nxt_flags[FLG_UNDER] = 1'b0;
                  end
                  default: begin
                     nxt_res = RST_RESULT; // Unknown code: zero words, flags kept
                  end
               endcase
            end
         end
         ST_DIV: begin
            if (div_if.done) begin
               nxt_st = ST_IDLE;
               nxt_valid = 1'b1;
               nxt_res = long_ff ? {dr, dq[31:0]} : {32'h0, dr[15:0], dq[15:0]};
               nxt_flags[FLG_CARRY] = 1'b0;
               nxt_flags[FLG_EQUALS] = (dq == 33'h0);
               nxt_flags[FLG_OVER] = sba_over(dq, long_ff);
               nxt_flags[FLG_UNDER] = sba_under(dq, long_ff);
            end
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
   end

   // Result and flag registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_ff <= ST_IDLE;
         res_ff <= RST_RESULT;
         flags_ff <= RST_FLAGS;
         valid_ff <= 1'b0;
         long_ff <= 1'b0;
         divz_ff <= 1'b0;
         dvd_ff <= 32'h0;
      end else begin
         st_ff <= nxt_st;
         res_ff <= nxt_res;
         flags_ff <= nxt_flags;
         valid_ff <= nxt_valid;
         long_ff <= nxt_long;
         divz_ff <= nxt_divz;
         dvd_ff <= nxt_dvd;
      end
   end

   // Registered outputs
   assign res_valid = valid_ff;
   assign res_w0 = res_ff[15:0];
   assign res_w1 = res_ff[31:16];
   assign res_w2 = res_ff[47:32];
   assign res_w3 = res_ff[63:48];
   assign flag_carry = flags_ff[FLG_CARRY];
   assign flag_equals = flags_ff[FLG_EQUALS];
   assign flag_overflow = flags_ff[FLG_OVER];
   assign flag_underflow = flags_ff[FLG_UNDER];

   sequence s_div_accept;
      accept && is_div;
   endsequence

   sequence s_div_wait;
      !res_valid [*8] ##26 res_valid;
   endsequence

   AST_FAST_RESULT: assert property (@(posedge clock) disable iff (sys_rst)
      accept && !is_div |=> res_valid && op_ready)
      else $error("single-cycle operation gave no result");

   AST_DIV_LATENCY: assert property (@(posedge clock) disable iff (sys_rst)
      s_div_accept |=> !op_ready ##0 s_div_wait)
      else $error("divide result not seen 34 cycles after request");

   AST_EQUALS_ADD: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == binary_add_long) |=> flag_equals == ({res_w1, res_w0} == 32'h0))
      else $error("equals flag does not match long sum");

   AST_FLAGS_ONLY_ON_RESULT: assert property (@(posedge clock) disable iff (sys_rst)
      !$stable(flags_ff) |-> res_valid)
      else $error("flags changed without a result");

   AST_WORD_ADD_OVER: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == binary_add_word) && !opnd_a_lo[15] && !opnd_b_lo[15] |=>
      flag_overflow == res_w0[15] && !flag_underflow)
      else $error("word add overflow wrong");

   AST_LONG_ADD_UNDER: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == binary_add_long) && opnd_a_hi[15] && opnd_b_hi[15] |=>
      flag_underflow == !res_w1[15] && !flag_overflow)
      else $error("long add underflow wrong");

   AST_LONG_SUB_OVER: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == binary_subtract_long) && !opnd_a_hi[15] && opnd_b_hi[15] |=>
      flag_overflow == res_w1[15])
      else $error("long subtract overflow wrong");

   AST_SUB_CARRY: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == binary_subtract_word) |=>
      flag_carry == ($signed($past(opnd_a_lo)) < $signed($past(opnd_b_lo))))
      else $error("subtract carry does not mark a negative result");

   AST_NEG_MIN: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == twos_complement_word) |=>
      flag_underflow == ($past(opnd_a_lo) == WORD_MIN) && !flag_carry && !flag_overflow)
      else $error("word negate underflow wrong");

   AST_MUL_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == signed_multiply_word) |=> !flag_carry && !flag_overflow && !flag_underflow
      && flag_equals == ({res_w1, res_w0} == 32'h0) && {res_w3, res_w2} == 32'h0)
      else $error("multiply flags not cleared");

   AST_ADD_CARRY: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == binary_add_word) |=>
      flag_carry == (res_w0 < $past(opnd_a_lo)))
      else $error("word add carry does not match wrapped sum");

   AST_LONG_ADD_CARRY: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == binary_add_long) |=>
      flag_carry == ({res_w1, res_w0} < {$past(opnd_a_hi), $past(opnd_a_lo)}))
      else $error("long add carry does not match wrapped sum");

   AST_WORD_SUB_UNDER: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == binary_subtract_word) && opnd_a_lo[15] && !opnd_b_lo[15] |=>
      flag_underflow == !res_w0[15] && !flag_overflow)
      else $error("word subtract underflow wrong");

   AST_LONG_NEG_MIN: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == twos_complement_long) |=>
      flag_underflow == ({$past(opnd_a_hi), $past(opnd_a_lo)} == LONG_MIN) && !flag_carry && !flag_overflow)
      else $error("long negate underflow wrong");

   AST_NEG_EQUALS: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == twos_complement_word) |=>
      flag_equals == (res_w0 == 16'h0) && {res_w3, res_w2, res_w1} == 48'h0)
      else $error("word negate equals flag or upper words wrong");

   AST_LONG_MUL_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code == signed_multiply_long) |=> !flag_carry && !flag_overflow && !flag_underflow
      && flag_equals == ({res_w3, res_w2, res_w1, res_w0} == 64'h0))
      else $error("long multiply flags not cleared");

   AST_UNKNOWN_KEEPS: assert property (@(posedge clock) disable iff (sys_rst)
      accept && (op_code > 4'h9) |=> res_valid && $stable(flags_ff)
      && {res_w3, res_w2, res_w1, res_w0} == 64'h0)
      else $error("unknown code changed flags or left words");

   AST_DIV_FLAGS: assert property (@(posedge clock) disable iff (sys_rst)
      (st_ff == ST_DIV) && div_if.done |=> res_valid && !flag_carry && !flag_underflow)
      else $error("divide result flags wrong");

   AST_BUSY_NO_RESULT: assert property (@(posedge clock) disable iff (sys_rst)
      (st_ff == ST_DIV) && !div_if.done |=> !res_valid && !op_ready)
      else $error("result or ready seen while dividing");

endmodule // sba_alu

`default_nettype wire

// ### test_sba_alu.sv
`timescale 1ns/1ps
`default_nettype none

module test_sba_alu
   import sba_pkg::*;
;
   logic clock;
   logic sys_rst;
   logic op_valid;
   logic op_ready;
   logic [3:0] op_code;
   logic [15:0] opnd_a_lo;
   logic [15:0] opnd_a_hi;
   logic [15:0] opnd_b_lo;
   logic [15:0] opnd_b_hi;
   logic res_valid;
   logic [15:0] res_w0;
   logic [15:0] res_w1;
   logic [15:0] res_w2;
   logic [15:0] res_w3;
   logic flag_carry;
   logic flag_equals;
   logic flag_overflow;
   logic flag_underflow;
   int errors;
   int cmp_count;
   logic [3:0] exp_flags;
   logic [63:0] seen_flags;

   // Flags as seen, in the reference layout
   assign seen_flags = {60'h0, flag_underflow, flag_overflow, flag_equals, flag_carry};

   sba_alu i_sba_alu (
      .clock(clock),
      .sys_rst(sys_rst),
      .op_valid(op_valid),
      .op_ready(op_ready),
      .op_code(op_code),
      .opnd_a_lo(opnd_a_lo),
      .opnd_a_hi(opnd_a_hi),
      .opnd_b_lo(opnd_b_lo),
      .opnd_b_hi(opnd_b_hi),
      .res_valid(res_valid),
      .res_w0(res_w0),
      .res_w1(res_w1),
      .res_w2(res_w2),
      .res_w3(res_w3),
      .flag_carry(flag_carry),
      .flag_equals(flag_equals),
      .flag_overflow(flag_overflow),
      .flag_underflow(flag_underflow)
   );

   // Free-running 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Counts, verdict and end of run
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // One comparison, reported at once on mismatch
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Reference result: {underflow, overflow, equals, carry, words}
   function automatic logic [67:0] ref_op(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
      logic lg;
      longint x, y, e, q, r, mx, mn;
      logic [63:0] w, m;
      logic [32:0] s;
      logic c, z, o, u, dv;
      lg = (op > 4'h4);
      x = lg ? longint'($signed(a)) : longint'($signed(a[15:0]));
      y = lg ? longint'($signed(b)) : longint'($signed(b[15:0]));
      mx = lg ? 64'sh7fff_ffff : 64'sh7fff;
      mn = -mx - 1;
      m = lg ? 64'hffff_ffff : 64'hffff;
      s = lg ? ({1'b0, a} + {1'b0, b}) : ({17'h0, a[15:0]} + {17'h0, b[15:0]});
      {c, z, o, u, dv} = 5'h0;
      w = 64'h0;
      case (op)
         4'h0, 4'h5: begin
            e = -x;
            u = (x == mn);
            w = e & m;
         end
         4'h1, 4'h6: begin
            e = x + y;
            c = lg ? s[32] : s[16];
            o = e > mx;
            u = e < mn;
            w = e & m;
         end
         4'h2, 4'h7: begin
            e = x - y;
            c = e < 0;
            o = e > mx;
            u = e < mn;
            w = e & m;
         end
         4'h3, 4'h8: begin
            e = x * y;
            w = lg ? e : (e & 64'hffff_ffff);
         end
         default: begin
            dv = 1'b1;
            q = (y == 0) ? 0 : x / y;
            r = (y == 0) ? x : x % y;
            o = (x == mn) && (y == -1);
            w = lg ? {r[31:0], q[31:0]} : {32'h0, r[15:0], q[15:0]};
            z = lg ? (q[31:0] == 32'h0) : (q[15:0] == 16'h0);
         end
      endcase
      if (!dv) begin
         z = (w == 64'h0);
      end
      ref_op = {u, o, z, c, w};
   endfunction

   // Idle outputs after reset
   task automatic check_idle();
      @(negedge clock);
      chk("res_valid", 64'h0, {63'h0, res_valid});
      chk("words", 64'h0, {res_w3, res_w2, res_w1, res_w0});
      chk("flags", 64'h0, seen_flags);
      chk("op_ready", 64'h1, {63'h0, op_ready});
      exp_flags = 4'h0;
   endtask

   // One request, then the result with its latency and flags
   task automatic run_op(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
      logic [67:0] r;
      logic dv;
      int n;
      r = (op > 4'h9) ? {exp_flags, 64'h0} : ref_op(op, a, b);
      dv = (op == 4'h4) || (op == 4'h9);
      chk("op_ready idle", 64'h1, {63'h0, op_ready});
      @(posedge clock);
      op_valid <= 1'b1;
      op_code <= op;
      {opnd_a_hi, opnd_a_lo} <= a;
      {opnd_b_hi, opnd_b_lo} <= b;
      @(posedge clock);
      op_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clock);
         n++;
         if (res_valid !== 1'b1) begin
            chk("flags held", {60'h0, exp_flags}, seen_flags);
            if (dv) begin
               chk("op_ready busy", 64'h0, {63'h0, op_ready});
            end
         end
      end while (res_valid !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         $display("CHECK FAILED res_valid expected 1 seen timeout");
         give_verdict();
      end else begin
         chk("latency", dv ? 64'd34 : 64'd1, 64'(n));
         chk("words", r[63:0], {res_w3, res_w2, res_w1, res_w0});
         chk("flags", {60'h0, r[67:64]}, seen_flags);
         exp_flags = r[67:64];
      end
   endtask

   // Main sequence
   initial begin
      errors = 0;
      cmp_count = 0;
      exp_flags = 4'h0;
      sys_rst = 1'b1;
      op_valid = 1'b0;
      op_code = 4'h0;
      {opnd_a_hi, opnd_a_lo, opnd_b_hi, opnd_b_lo} = 64'h0;
      repeat (4) @(posedge clock);
      sys_rst <= 1'b0;
      check_idle();
      $display("Test reset done");
      run_op(twos_complement_word, 32'h0001, 32'h0);
      run_op(twos_complement_word, 32'h0000, 32'h0);
      run_op(twos_complement_word, 32'h8000, 32'h0);
      run_op(binary_add_word, 32'h7fff, 32'h0001);
      run_op(binary_add_word, 32'h8000, 32'hffff);
      run_op(binary_add_word, 32'h04d2, 32'hff85);
      run_op(binary_add_word, 32'h0001, 32'hffff);
      run_op(binary_add_word, 32'h1234, 32'h0100);
      run_op(binary_subtract_word, 32'h0001, 32'h0002);
      run_op(binary_subtract_word, 32'h8000, 32'h0001);
      run_op(binary_subtract_word, 32'h7fff, 32'hffff);
      run_op(binary_subtract_word, 32'h0005, 32'h0005);
      run_op(signed_multiply_word, 32'h0457, 32'h04bc);
      run_op(signed_multiply_word, 32'h8000, 32'h8000);
      run_op(signed_multiply_word, 32'h0000, 32'hfb2e);
      $display("Test word operations done");
      run_op(signed_divide_word, 32'h7fff, 32'hfb2e);
      run_op(signed_divide_word, 32'h8000, 32'hffff);
      run_op(signed_divide_word, 32'h1234, 32'h0000);
      $display("Test word divide done");
      run_op(twos_complement_long, 32'h8000_0000, 32'h0);
      run_op(twos_complement_long, 32'h0000_0001, 32'h0);
      run_op(binary_add_long, 32'h7fff_ffff, 32'h0000_0001);
      run_op(binary_add_long, 32'h8000_0000, 32'hffff_ffff);
      run_op(binary_add_long, 32'h0001_ffff, 32'h0000_0001);
      run_op(binary_subtract_long, 32'h0000_0000, 32'h0000_0001);
      run_op(binary_subtract_long, 32'h7fff_ffff, 32'hffff_ffff);
      run_op(binary_subtract_long, 32'h8000_0000, 32'h0000_0001);
      run_op(signed_multiply_long, 32'h0000_0457, 32'h0000_04bc);
      run_op(signed_multiply_long, 32'h8000_0000, 32'h8000_0000);
      $display("Test long operations done");
      run_op(signed_divide_long, 32'h0014_5bab, 32'hffff_fb2e);
      run_op(signed_divide_long, 32'h8000_0000, 32'hffff_ffff);
      run_op(signed_divide_long, 32'h0000_0007, 32'h0000_0000);
      $display("Test long divide done");
      run_op(binary_add_word, 32'h8000, 32'h8000);
      run_op(4'ha, 32'h1111, 32'h2222);
      run_op(4'hf, 32'h3333, 32'h4444);
      $display("Test unknown codes done");
      @(posedge clock);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      check_idle();
      run_op(binary_subtract_word, 32'h0000, 32'h0001);
      $display("Test mid-run reset done");
      give_verdict();
   end

endmodule // test_sba_alu

`default_nettype wire
